// ---- design/pcrc_pkg.sv ----
// package: register map, field positions and reset values of the crc block
package pcrc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_POLY = 4'h2;
    localparam logic [3:0] OFF_DATA = 4'h4;
    localparam logic [3:0] OFF_RESULT = 4'h6;
    localparam int CTRL_IDLE_STOP = 13;
    localparam int CTRL_COUNT_HI = 12;
    localparam int CTRL_COUNT_LO = 8;
    localparam int CTRL_FULL = 7;
    localparam int CTRL_EMPTY = 6;
    localparam int CTRL_GO = 4;
    localparam int CTRL_LEN_HI = 3;
    localparam int CTRL_LEN_LO = 0;
    localparam logic [15:0] POLY_RESET = 16'h0000;
    localparam logic [3:0] LEN_RESET = 4'h0;
    localparam logic [3:0] LEN_SHALLOW_MAX = 4'h7;
    localparam logic [4:0] DEPTH_SHALLOW = 5'h10;
    localparam logic [4:0] DEPTH_DEEP = 5'h08;
    localparam logic [15:0] POLY_TAP_MASK = 16'hFFFE;
    typedef enum logic [1:0] {
        PCRC_IDLE = 2'b00,
        PCRC_SHIFT = 2'b01
    } pcrc_state_t;
endpackage : pcrc_pkg

// ---- design/pcrc_lfsr.sv ----
// linear feedback shift register stepping one bit per cycle with clk_en and step set and clear low
`timescale 1ns/1ps
module pcrc_lfsr (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // control
    input wire logic step,
    input wire logic din,
    input wire logic clear,
    input wire logic [3:0] len,
    input wire logic [15:0] poly,
    // result
    output logic [15:0] crc
);
    logic [15:0] crc_q;
    logic [15:0] crc_d;
    logic fb;

    always_comb begin
        // feedback from the top stage at the programmed length
        fb = crc_q[len] ^ din;
        crc_d = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i == 0) begin
                crc_d[i] = fb;
            end else if (i <= int'(len)) begin
                crc_d[i] = crc_q[i-1] ^ (fb & poly[i]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            crc_q <= 16'h0000;
        end else if (clk_en) begin
            if (clear) begin
                crc_q <= 16'h0000;
            end else if (step) begin
                crc_q <= crc_d;
            end
        end
    end

    assign crc = crc_q;
endmodule : pcrc_lfsr

// ---- design/pcrc_top.sv ----
// programmable crc generator with word fifo and register port
//
// Operation
// - taps from term bits, length from field
// - x^0 always applied, x^(length+1) implicit
// - fifo eight deep above seven, else sixteen
// - data words are length plus one bits
// - count increments when word is written
// - shift while go set and count nonzero
// - count decrements after word lsb shifted
// - full at depth, empty at zero
// - write when full rolls count to zero
// - event when count goes one to zero
// - sleep freezes state, resumes later
// - idle stop bit makes idle like sleep
// - clearing go stops only once empty
// - length field in control bits 3:0
// - count, idle stop, full, empty positions
`timescale 1ns/1ps
module pcrc_top #(
    parameter int DEPTH_MAX = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // power state
    input wire logic sleep_req,
    input wire logic idle_req,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // event
    output logic drain_event
);
    logic [15:0] poly_q;
    logic [3:0] len_q;
    logic go_q;
    logic idle_stop_q;
    logic [4:0] count_q;
    logic [3:0] rd_ptr_q;
    logic [3:0] wr_ptr_q;
    logic [3:0] bit_q;
    logic [15:0] mem_q [DEPTH_MAX];
    logic [15:0] reg_rdata_q;
    logic drain_q;
    pcrc_pkg::pcrc_state_t state_q;
    logic run;
    logic wr_data;
    logic shifting;
    logic word_done;
    logic [4:0] depth;
    logic full;
    logic empty;
    logic [15:0] crc;
    logic [15:0] cur_word;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction : hit

    // circular pointer step, wraps at the depth in force now
    function automatic logic [3:0] ptr_next(
            input logic [3:0] p,
            input logic [4:0] dep);
        ptr_next = (5'(p) + 5'h01 == dep) ? 4'h0 : p + 4'h1;
    endfunction : ptr_next

    // sleep or stopped idle freezes fifo and shifter; a drain event already out still clears next cycle
    assign run = clk_en && !sleep_req && !(idle_req && idle_stop_q);
    // length above seven halves the fifo since words are wider
    assign depth = (len_q > pcrc_pkg::LEN_SHALLOW_MAX)
        ? pcrc_pkg::DEPTH_DEEP : pcrc_pkg::DEPTH_SHALLOW;
    assign full = (count_q == depth);
    assign empty = (count_q == 5'h00);
    assign wr_data = reg_wr && hit(reg_addr, pcrc_pkg::OFF_DATA);
    // go cleared while words remain keeps running until empty
    assign shifting = (state_q == pcrc_pkg::PCRC_SHIFT) && !empty;
    assign cur_word = mem_q[rd_ptr_q];
    assign word_done = shifting && (bit_q == len_q);

    // control and polynomial registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            poly_q <= pcrc_pkg::POLY_RESET;
            len_q <= pcrc_pkg::LEN_RESET;
            go_q <= 1'b0;
            idle_stop_q <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && hit(reg_addr, pcrc_pkg::OFF_CTRL)) begin
                len_q <= reg_wdata[pcrc_pkg::CTRL_LEN_HI:
                    pcrc_pkg::CTRL_LEN_LO];
                go_q <= reg_wdata[pcrc_pkg::CTRL_GO];
                idle_stop_q <= reg_wdata[pcrc_pkg::CTRL_IDLE_STOP];
            end
            if (reg_wr && hit(reg_addr, pcrc_pkg::OFF_POLY)) begin
                poly_q <= reg_wdata & pcrc_pkg::POLY_TAP_MASK;
            end
        end
    end

    // shifter state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= pcrc_pkg::PCRC_IDLE;
        end else if (run) begin
            if (go_q) begin
                state_q <= pcrc_pkg::PCRC_SHIFT;
            end else if (empty) begin
                state_q <= pcrc_pkg::PCRC_IDLE;
            end
        end
    end

    // fifo storage, whole 16-bit write kept, low length+1 bits used
    always_ff @(posedge core_clk) begin
        if (run && wr_data) begin
            mem_q[wr_ptr_q] <= reg_wdata;
        end
    end

    // pointers, bit index and word count
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count_q <= 5'h00;
            rd_ptr_q <= 4'h0;
            wr_ptr_q <= 4'h0;
            bit_q <= 4'h0;
        end else if (run) begin
            if (wr_data && full) begin
                // overflow discards everything, no drain event follows
                count_q <= 5'h00;
                rd_ptr_q <= 4'h0;
                wr_ptr_q <= 4'h0;
                bit_q <= 4'h0;
            end else begin
                if (wr_data && !word_done) begin
                    count_q <= count_q + 5'h01;
                end else if (word_done && !wr_data) begin
                    count_q <= count_q - 5'h01;
                end
                if (wr_data) begin
                    wr_ptr_q <= ptr_next(wr_ptr_q, depth);
                end
                if (word_done) begin
                    bit_q <= 4'h0;
                    rd_ptr_q <= ptr_next(rd_ptr_q, depth);
                end else if (shifting) begin
                    bit_q <= bit_q + 4'h1;
                end
            end
        end
    end

    // drain event: one pulse when count steps from one to zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            drain_q <= 1'b0;
        end else if (clk_en) begin
            drain_q <= run && word_done && !wr_data
                && (count_q == 5'h01);
        end
    end

    // msb first into the engine
    pcrc_lfsr u_lfsr (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(run),
        .step(shifting),
        .din(cur_word[len_q - bit_q]),
        .clear(1'b0),
        .len(len_q),
        .poly(poly_q),
        .crc(crc)
    );

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata_q <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata_q <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    pcrc_pkg::OFF_CTRL: begin
                        reg_rdata_q <= {2'b00, idle_stop_q, count_q,
                            full, empty, 1'b0, go_q, len_q};
                    end
                    pcrc_pkg::OFF_POLY: reg_rdata_q <= poly_q;
                    pcrc_pkg::OFF_DATA: reg_rdata_q <= crc;
                    pcrc_pkg::OFF_RESULT: reg_rdata_q <= crc;
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign drain_event = drain_q;

    a_count_bound: assert property (@(posedge core_clk) disable iff (!rstn)
        count_q <= 5'h10)
        else $error("word count above sixteen");
    a_wrap_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        run && wr_data && full |=> count_q == 5'h00)
        else $error("overflow write did not clear count");
    a_drain_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        run && word_done && !wr_data && count_q == 5'h01
        |=> drain_event && empty)
        else $error("drain event missing");
    a_no_event: assert property (@(posedge core_clk) disable iff (!rstn)
        drain_event |-> $past(count_q) == 5'h01)
        else $error("spurious drain event");
    a_count_up: assert property (@(posedge core_clk) disable iff (!rstn)
        run && wr_data && !full && !word_done
        |=> count_q == $past(count_q) + 5'h01)
        else $error("count did not increment");
    a_count_down: assert property (@(posedge core_clk) disable iff (!rstn)
        run && word_done && !wr_data
        |=> count_q == $past(count_q) - 5'h01)
        else $error("count did not decrement");
    a_freeze_sleep: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && sleep_req |=> $stable(count_q) && $stable(bit_q))
        else $error("state moved during sleep");
    a_depth_sel: assert property (@(posedge core_clk) disable iff (!rstn)
        len_q > 4'h7 |-> depth == 5'h08)
        else $error("wrong depth for long polynomial");
    a_run_on: assert property (@(posedge core_clk) disable iff (!rstn)
        run && !go_q && !empty && state_q == pcrc_pkg::PCRC_SHIFT
        |=> state_q == pcrc_pkg::PCRC_SHIFT)
        else $error("shifter stopped before empty");
    a_go_start: assert property (@(posedge core_clk) disable iff (!rstn)
        run && go_q |=> state_q == pcrc_pkg::PCRC_SHIFT)
        else $error("shifter did not start on go");

    a_idle_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && idle_req && idle_stop_q
        |=> $stable(count_q) && $stable(state_q))
        else $error("state moved in stopped idle");

    a_idle_run: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && idle_req && !idle_stop_q && !sleep_req |-> run)
        else $error("idle froze with stop bit clear");

    a_poly_bit0: assert property (@(posedge core_clk) disable iff (!rstn)
        poly_q[0] == 1'b0)
        else $error("constant term stored in term register");

    a_poly_write: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && reg_wr && reg_addr == pcrc_pkg::OFF_POLY
        |=> poly_q == ($past(reg_wdata) & pcrc_pkg::POLY_TAP_MASK))
        else $error("term register write lost");

    a_ctrl_count: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && reg_rd && reg_addr == pcrc_pkg::OFF_CTRL
        |=> reg_rdata[12:8] == $past(count_q))
        else $error("count field misplaced in control read");

    a_rdata_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    a_wrap_ptrs: assert property (@(posedge core_clk) disable iff (!rstn)
        run && wr_data && full
        |=> rd_ptr_q == 4'h0 && wr_ptr_q == 4'h0)
        else $error("overflow left pointers");

    a_wrap_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        run && wr_data && full |=> !drain_event)
        else $error("overflow raised a drain event");

    // no step means the engine must hold, so a stray step is caught
    a_lfsr_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !(run && shifting) |=> $stable(crc))
        else $error("engine moved without a shift");

    a_bit_range: assert property (@(posedge core_clk) disable iff (!rstn)
        shifting |-> bit_q <= len_q)
        else $error("bit index beyond word length");

    c_full: cover property (@(posedge core_clk) disable iff (!rstn) full);
    c_word: cover property (@(posedge core_clk) disable iff (!rstn)
        word_done);
    c_idle_stop: cover property (@(posedge core_clk) disable iff (!rstn)
        clk_en && idle_req && idle_stop_q);
    c_drain: cover property (@(posedge core_clk) disable iff (!rstn)
        drain_event);
    c_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
        run && wr_data && full);
endmodule : pcrc_top

// ---- verification/programmable_crc_generator_tb_top.sv ----
// self-checking bench for the crc block over its register port
`timescale 1ns/1ps
module programmable_crc_generator_tb_top;
    logic core_clk;
    logic rstn;
    logic clk_en;
    logic sleep_req;
    logic idle_req;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic drain_event;
    int num_errors;
    int compares;
    int n_drain;
    logic [15:0] d;
    logic [15:0] crc_exp;

    pcrc_top #(.DEPTH_MAX(16)) i_dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .sleep_req(sleep_req),
        .idle_req(idle_req),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .drain_event(drain_event)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // pulses are one cycle wide, so one count per high sample
    always @(posedge core_clk) begin
        if (drain_event === 1'b1) n_drain <= n_drain + 1;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // taken at the closing edge, before the design clears it
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_ctrl(input logic [15:0] exp);
        rd(pcrc_pkg::OFF_CTRL, d);
        chk(d, exp);
    endtask : chk_ctrl

    // msb first, data folded into the feedback, x^0 always applied
    function automatic logic [15:0] crc_step(input logic [15:0] c,
            input logic [15:0] p, input logic [3:0] len,
            input logic [15:0] w);
        logic fb;
        logic [15:0] m;
        m = 16'hFFFF >> (4'hF - len);
        for (int b = 15; b >= 0; b--) begin
            if (b <= len) begin
                fb = c[len] ^ w[b];
                c = ((c << 1) ^ (fb ? (p | 16'h0001) : 16'h0000)) & m;
            end
        end
        return c;
    endfunction : crc_step

    task automatic summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #400000;
        num_errors++;
        summarize();
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        sleep_req = 1'b0;
        idle_req = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        num_errors = 0;
        compares = 0;
        n_drain = 0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        chk_ctrl(16'h0040);
        rd(pcrc_pkg::OFF_POLY, d);
        chk(d, 16'h0000);
        wr(pcrc_pkg::OFF_POLY, 16'hFFFF);
        rd(pcrc_pkg::OFF_POLY, d);
        chk(d, 16'hFFFE);
        // sixteen deep at length 7, count seen after every write
        wr(pcrc_pkg::OFF_CTRL, 16'h0007);
        for (int i = 1; i <= 16; i++) begin
            wr(pcrc_pkg::OFF_DATA, 16'(i));
            d = 16'h0007 | 16'(i << 8) | (i == 16 ? 16'h0080 : 16'h0000);
            chk_ctrl(d);
        end
        wr(pcrc_pkg::OFF_DATA, 16'h00AA);
        chk_ctrl(16'h0047);
        // eight deep once the length field is above 7
        wr(pcrc_pkg::OFF_CTRL, 16'h0008);
        for (int i = 1; i <= 8; i++) wr(pcrc_pkg::OFF_DATA, 16'h0100);
        chk_ctrl(16'h0888);
        wr(pcrc_pkg::OFF_DATA, 16'h0101);
        chk_ctrl(16'h0048);
        chk(16'(n_drain), 16'h0000);
        // frozen block drops the write
        sleep_req <= 1'b1;
        wr(pcrc_pkg::OFF_DATA, 16'h0055);
        sleep_req <= 1'b0;
        chk_ctrl(16'h0048);
        wr(pcrc_pkg::OFF_CTRL, 16'h2008);
        idle_req <= 1'b1;
        wr(pcrc_pkg::OFF_DATA, 16'h0055);
        idle_req <= 1'b0;
        chk_ctrl(16'h2048);
        // two words drained, go dropped early must not cut it short
        wr(pcrc_pkg::OFF_CTRL, 16'h0007);
        wr(pcrc_pkg::OFF_POLY, 16'h0006);
        wr(pcrc_pkg::OFF_DATA, 16'h00A5);
        wr(pcrc_pkg::OFF_DATA, 16'h003C);
        wr(pcrc_pkg::OFF_CTRL, 16'h0017);
        wr(pcrc_pkg::OFF_CTRL, 16'h0007);
        d = 16'h0000;
        for (int i = 0; i < 50 && d[6] !== 1'b1; i++) begin
            rd(pcrc_pkg::OFF_CTRL, d);
        end
        chk(d, 16'h0047);
        chk(16'(n_drain), 16'h0001);
        crc_exp = crc_step(16'h0000, 16'h0006, 4'h7, 16'h00A5);
        crc_exp = crc_step(crc_exp, 16'h0006, 4'h7, 16'h003C);
        rd(pcrc_pkg::OFF_RESULT, d);
        chk(d & 16'h00FF, crc_exp);
        summarize();
    end
endmodule : programmable_crc_generator_tb_top
